// *** verilog/quadrature_position_control.sv ***
// Control register and position counter of the quadrature position control block
//
// Overview of operation
// - Counters run only while counter enable set
// - Idle-halt bit stops operation during idle
// - Control bit 14 unused, reads zero
// - Three-bit init mode; 111 reserved
// - Mode 110 counts modulo
// - Mode 101 resets counter at compare equality
// - Mode 100 loads on second index after home
// - Mode 011 loads on first index after home
// - Mode 010 loads on next index
// - Mode 001 resets on every index
// - Mode 000 index leaves counter alone
// - Phase-B match level selected by bit 9
// - Phase-A match level selected by bit 8
`timescale 1ns/1ps
module qpc_quadrature_position_control
    import qpc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regReadData,
    // Device state
    input wire logic cpuIdle,
    // Encoder pins
    input wire logic phaseAInput,
    input wire logic phaseBInput,
    input wire logic indexInput,
    input wire logic homeInput,
    // Status outputs
    output logic [15:0] position,
    output logic counterRunning
);
    logic [15:0] controlQ;
    logic [15:0] initValueQ;
    logic [15:0] geCompareQ;
    logic [15:0] moduloQ;
    logic [15:0] positionQ;
    logic [15:0] positionD;
    logic [15:0] readDataQ;
    logic runningQ;
    logic [3:0] syncQ1;
    logic [3:0] syncQ2;
    logic [3:0] pinsQ;
    logic [1:0] quadPrev;
    logic indexPrev;
    logic homePrev;
    logic indexEvent;
    logic homeEvent;
    logic stepUp;
    logic stepDown;
    logic active;
    qpc_mode_t mode;
    qpc_seq_t seqQ;
    logic seqLoad;

    assign mode = qpc_mode_t'(controlQ[QPC_MODE_HI:QPC_MODE_LO]);
    // Running needs enable, and not idle when halt is requested
    assign active = controlQ[QPC_BIT_ENABLE] &&
        !(controlQ[QPC_BIT_IDLE_HALT] && cpuIdle);

    // Two-stage synchronisers on all encoder pins; stage one read by stage two only
    always_ff @(posedge clk) begin
        if (reset) begin
            syncQ1 <= 4'h0;
            syncQ2 <= 4'h0;
            pinsQ <= 4'h0;
        end else begin
            syncQ1 <= {homeInput, indexInput, phaseBInput, phaseAInput};
            syncQ2 <= syncQ1;
            pinsQ <= syncQ2;
        end
    end

    // Index qualified by both phase levels; rising edge of the raw index pin, gated by the match
    assign indexEvent = syncQ2[2] && !indexPrev &&
        (syncQ2[1] == controlQ[QPC_BIT_MATCH_B]) &&
        (syncQ2[0] == controlQ[QPC_BIT_MATCH_A]);
    assign homeEvent = syncQ2[3] && !homePrev;
    // x4 decode from the previous and present phase pair
    assign stepUp = (quadPrev == 2'h0 && syncQ2[1:0] == 2'h1) ||
        (quadPrev == 2'h1 && syncQ2[1:0] == 2'h3) ||
        (quadPrev == 2'h3 && syncQ2[1:0] == 2'h2) ||
        (quadPrev == 2'h2 && syncQ2[1:0] == 2'h0);
    assign stepDown = (quadPrev == 2'h0 && syncQ2[1:0] == 2'h2) ||
        (quadPrev == 2'h2 && syncQ2[1:0] == 2'h3) ||
        (quadPrev == 2'h3 && syncQ2[1:0] == 2'h1) ||
        (quadPrev == 2'h1 && syncQ2[1:0] == 2'h0);

    // Edge history, qualified index edge is tracked on the raw pin
    always_ff @(posedge clk) begin
        if (reset) begin
            quadPrev <= 2'h0;
            indexPrev <= 1'b0;
            homePrev <= 1'b0;
        end else begin
            quadPrev <= syncQ2[1:0];
            indexPrev <= syncQ2[2];
            homePrev <= syncQ2[3];
        end
    end

    // Home then index sequencing for the load-after-home modes
    always_ff @(posedge clk) begin
        if (reset) begin
            seqQ <= QPC_SEQ_WAIT_HOME;
        end else if (!active) begin
            seqQ <= QPC_SEQ_WAIT_HOME;
        end else begin
            case (seqQ)
                QPC_SEQ_WAIT_HOME: begin
                    if (homeEvent) begin
                        seqQ <= QPC_SEQ_WAIT_FIRST;
                    end
                end
                QPC_SEQ_WAIT_FIRST: begin
                    if (indexEvent) begin
                        seqQ <= (mode == QPC_MODE_LOAD_SECOND_HOME) ?
                            QPC_SEQ_WAIT_SECOND : QPC_SEQ_DONE;
                    end
                end
                QPC_SEQ_WAIT_SECOND: begin
                    if (indexEvent) begin
                        seqQ <= QPC_SEQ_DONE;
                    end
                end
                QPC_SEQ_DONE: begin
                    if (homeEvent) begin
                        seqQ <= QPC_SEQ_WAIT_FIRST;
                    end
                end
                default: begin
                    seqQ <= QPC_SEQ_WAIT_HOME;
                end
            endcase
        end
    end

    // Load strobe on the index that completes the home sequence
    assign seqLoad = indexEvent &&
        ((mode == QPC_MODE_LOAD_FIRST_HOME && seqQ == QPC_SEQ_WAIT_FIRST) ||
        (mode == QPC_MODE_LOAD_SECOND_HOME && seqQ == QPC_SEQ_WAIT_SECOND));

    // Next position; index actions take priority over a step in the same cycle
    always_comb begin
        positionD = positionQ;
        if (stepUp) begin
            if (mode == QPC_MODE_MODULO && positionQ == moduloQ) begin
                positionD = QPC_WORD_RESET;
            end else begin
                positionD = positionQ + QPC_ONE;
            end
        end else if (stepDown) begin
            if (mode == QPC_MODE_MODULO && positionQ == QPC_WORD_RESET) begin
                positionD = moduloQ;
            end else begin
                positionD = positionQ - QPC_ONE;
            end
        end
        case (mode)
            QPC_MODE_IGNORE: begin
            end
            QPC_MODE_RESET_EACH: begin
                if (indexEvent) begin
                    positionD = QPC_WORD_RESET;
                end
            end
            QPC_MODE_LOAD_NEXT: begin
                if (indexEvent) begin
                    positionD = initValueQ;
                end
            end
            QPC_MODE_LOAD_FIRST_HOME, QPC_MODE_LOAD_SECOND_HOME: begin
                if (seqLoad) begin
                    positionD = initValueQ;
                end
            end
            QPC_MODE_RESET_GE: begin
                if (positionQ == geCompareQ) begin
                    positionD = QPC_WORD_RESET;
                end
            end
            default: begin
            end // Modulo handled above; reserved code only counts
        endcase
    end

    // Position register, counting frozen while disabled or halted in idle; software writes still load it
    always_ff @(posedge clk) begin
        if (reset) begin
            positionQ <= QPC_WORD_RESET;
        end else if (regWrite && regAddr == QPC_ADDR_POSITION) begin
            positionQ <= regWriteData;
        end else if (active) begin
            positionQ <= positionD;
        end
    end

    // Software registers stay writable regardless of enable
    always_ff @(posedge clk) begin
        if (reset) begin
            controlQ <= QPC_CONTROL_RESET;
            initValueQ <= QPC_WORD_RESET;
            geCompareQ <= QPC_WORD_RESET;
            moduloQ <= QPC_MODULO_RESET;
        end else if (regWrite) begin
            case (regAddr)
                QPC_ADDR_CONTROL: controlQ <= regWriteData & QPC_CONTROL_MASK;
                QPC_ADDR_INIT_VALUE: initValueQ <= regWriteData;
                QPC_ADDR_GE_COMPARE: geCompareQ <= regWriteData;
                QPC_ADDR_MODULO: moduloQ <= regWriteData;
                default: begin
                end
            endcase
        end
    end

    // Read data valid one cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (reset) begin
            readDataQ <= QPC_WORD_RESET;
        end else if (regRead) begin
            case (regAddr)
                QPC_ADDR_CONTROL: readDataQ <= controlQ & QPC_CONTROL_MASK;
                QPC_ADDR_INIT_VALUE: readDataQ <= initValueQ;
                QPC_ADDR_GE_COMPARE: readDataQ <= geCompareQ;
                QPC_ADDR_MODULO: readDataQ <= moduloQ;
                QPC_ADDR_POSITION: readDataQ <= positionQ;
                QPC_ADDR_STATUS: readDataQ <= {12'h000, seqQ, pinsQ[3:2]};
                default: readDataQ <= QPC_WORD_RESET;
            endcase
        end else begin
            readDataQ <= QPC_WORD_RESET;
        end
    end

    // Running flag registered so the output comes from a flop
    always_ff @(posedge clk) begin
        if (reset) begin
            runningQ <= 1'b0;
        end else begin
            runningQ <= active;
        end
    end

    assign regReadData = readDataQ;
    assign position = positionQ;
    assign counterRunning = runningQ;

    // Checks
    sequence qpcWriteControlEnabled;
        regWrite && regAddr == QPC_ADDR_CONTROL && regWriteData[QPC_BIT_ENABLE];
    endsequence
    sequence qpcCounterFrozen;
        !active && !(regWrite && regAddr == QPC_ADDR_POSITION);
    endsequence

    chk_frozen_when_off: assert property (@(posedge clk) disable iff (reset)
        qpcCounterFrozen |=> positionQ == $past(positionQ))
        else $error("position moved while inactive");
    chk_idle_halt: assert property (@(posedge clk) disable iff (reset)
        controlQ[QPC_BIT_IDLE_HALT] && cpuIdle |=> !runningQ)
        else $error("running flag set during halted idle");
    chk_enable_run: assert property (@(posedge clk) disable iff (reset)
        qpcWriteControlEnabled ##1 (!cpuIdle) |=> runningQ)
        else $error("enable write did not start counter");
    chk_bit14_zero: assert property (@(posedge clk) disable iff (reset)
        regRead && regAddr == QPC_ADDR_CONTROL |=> !regReadData[QPC_BIT_UNUSED])
        else $error("unused control bit read as one");
    chk_reset_each: assert property (@(posedge clk) disable iff (reset)
        active && mode == QPC_MODE_RESET_EACH && indexEvent &&
        !(regWrite && regAddr == QPC_ADDR_POSITION) |=> positionQ == QPC_WORD_RESET)
        else $error("index did not clear position");
    chk_load_next: assert property (@(posedge clk) disable iff (reset)
        active && mode == QPC_MODE_LOAD_NEXT && indexEvent &&
        !regWrite |=> positionQ == $past(initValueQ))
        else $error("index did not load init value");
    chk_ge_reset: assert property (@(posedge clk) disable iff (reset)
        active && mode == QPC_MODE_RESET_GE && positionQ == geCompareQ &&
        !regWrite |=> positionQ == QPC_WORD_RESET)
        else $error("compare equality did not reset");
    chk_modulo_wrap: assert property (@(posedge clk) disable iff (reset)
        active && mode == QPC_MODE_MODULO && stepUp && positionQ == moduloQ &&
        !regWrite |=> positionQ == QPC_WORD_RESET)
        else $error("modulo wrap missed");
    // Index edge with phases off their match levels must leave the count alone
    chk_index_qual: assert property (@(posedge clk) disable iff (reset)
        active && mode == QPC_MODE_RESET_EACH && syncQ2[2] && !indexPrev &&
        (syncQ2[1:0] != {controlQ[QPC_BIT_MATCH_B], controlQ[QPC_BIT_MATCH_A]}) &&
        !stepUp && !stepDown && !regWrite |=> positionQ == $past(positionQ))
        else $error("index accepted with wrong phase levels");
    chk_ignore_index: assert property (@(posedge clk) disable iff (reset)
        active && mode == QPC_MODE_IGNORE && !stepUp && !stepDown &&
        !regWrite |=> positionQ == $past(positionQ))
        else $error("index disturbed counter in ignore mode");
    chk_second_load: assert property (@(posedge clk) disable iff (reset)
        active && mode == QPC_MODE_LOAD_SECOND_HOME && indexEvent &&
        seqQ == QPC_SEQ_WAIT_SECOND && !regWrite |=> positionQ == $past(initValueQ))
        else $error("second-index load did not happen");
endmodule // qpc_quadrature_position_control

// *** verilog/qpc_pkg.sv ***
// Package of constants for the quadrature position control block
package qpc_pkg;
    // Register map (word offsets on the plain register port)
    localparam logic [3:0] QPC_ADDR_CONTROL = 4'h0;
    localparam logic [3:0] QPC_ADDR_INIT_VALUE = 4'h1;
    localparam logic [3:0] QPC_ADDR_GE_COMPARE = 4'h2;
    localparam logic [3:0] QPC_ADDR_MODULO = 4'h3;
    localparam logic [3:0] QPC_ADDR_POSITION = 4'h4;
    localparam logic [3:0] QPC_ADDR_STATUS = 4'h5;
    // Control field positions
    localparam int QPC_BIT_ENABLE = 15;
    localparam int QPC_BIT_UNUSED = 14;
    localparam int QPC_BIT_IDLE_HALT = 13;
    localparam int QPC_MODE_HI = 12;
    localparam int QPC_MODE_LO = 10;
    localparam int QPC_BIT_MATCH_B = 9;
    localparam int QPC_BIT_MATCH_A = 8;
    // Writable bits of the control word; bit 14 and the low byte read zero
    localparam logic [15:0] QPC_CONTROL_MASK = 16'hBF00;
    localparam logic [15:0] QPC_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] QPC_WORD_RESET = 16'h0000;
    localparam logic [15:0] QPC_MODULO_RESET = 16'hFFFF;
    localparam logic [15:0] QPC_ONE = 16'h0001;
    // Initialisation modes
    typedef enum logic [2:0] {
        QPC_MODE_IGNORE = 3'h0,
        QPC_MODE_RESET_EACH = 3'h1,
        QPC_MODE_LOAD_NEXT = 3'h2,
        QPC_MODE_LOAD_FIRST_HOME = 3'h3,
        QPC_MODE_LOAD_SECOND_HOME = 3'h4,
        QPC_MODE_RESET_GE = 3'h5,
        QPC_MODE_MODULO = 3'h6,
        QPC_MODE_RESERVED = 3'h7
    } qpc_mode_t;
    // Home/index sequencing states
    typedef enum logic [1:0] {
        QPC_SEQ_WAIT_HOME = 2'h0,
        QPC_SEQ_WAIT_FIRST = 2'h1,
        QPC_SEQ_WAIT_SECOND = 2'h2,
        QPC_SEQ_DONE = 2'h3
    } qpc_seq_t;
endpackage

// *** testbench/qpc_encoder_model.sv ***
// Behavioural incremental encoder with phase, index and home outputs
`timescale 1ns/1ps
module qpc_encoder_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Commands from the bench
    input wire logic cmdStep,
    input wire logic cmdIndex,
    input wire logic cmdHome,
    input wire logic cmdBack,
    // Encoder pins
    output logic phaseA,
    output logic phaseB,
    output logic indexPin,
    output logic homePin
);
    logic [1:0] quadState_q;
    logic [1:0] indexLeft_q;
    logic [1:0] homeLeft_q;

    // Gray sequence, A leads B when stepping forward
    always_ff @(posedge clk) begin
        if (reset) begin
            quadState_q <= 2'h0;
        end else if (cmdStep) begin
            quadState_q <= quadState_q + 2'h1;
        end else if (cmdBack) begin
            quadState_q <= quadState_q - 2'h1; // Reverse rotation, B leads A
        end
    end
    assign phaseA = (quadState_q == 2'h1) || (quadState_q == 2'h2);
    assign phaseB = quadState_q[1];

    // Two-cycle index pulse so the synchroniser cannot miss it
    always_ff @(posedge clk) begin
        if (reset) begin
            indexLeft_q <= 2'h0;
        end else if (cmdIndex) begin
            indexLeft_q <= 2'h2;
        end else if (indexLeft_q != 2'h0) begin
            indexLeft_q <= indexLeft_q - 2'h1;
        end
    end
    assign indexPin = (indexLeft_q != 2'h0);

    // Home pulse, same width as index
    always_ff @(posedge clk) begin
        if (reset) begin
            homeLeft_q <= 2'h0;
        end else if (cmdHome) begin
            homeLeft_q <= 2'h2;
        end else if (homeLeft_q != 2'h0) begin
            homeLeft_q <= homeLeft_q - 2'h1;
        end
    end
    assign homePin = (homeLeft_q != 2'h0);
endmodule // qpc_encoder_model

// *** testbench/tb_quadrature_position_control.sv ***
// Self-checking testbench of the quadrature position control block
`timescale 1ns/1ps
module tb_quadrature_position_control;
    import qpc_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWriteData = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic cpuIdle = 1'b0;
    logic cmdStep = 1'b0;
    logic cmdIndex = 1'b0;
    logic cmdHome = 1'b0;
    logic cmdBack = 1'b0;
    logic [15:0] regReadData;
    logic [15:0] position;
    logic [15:0] rdVal;
    logic counterRunning;
    logic phaseAInput;
    logic phaseBInput;
    logic indexInput;
    logic homeInput;
    int mismatches = 0;
    int tests_run = 0;

    // 100 ns period
    always #50 clk = ~clk;

    qpc_quadrature_position_control i_dut (.clk(clk), .reset(reset), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadData(regReadData), .cpuIdle(cpuIdle), .phaseAInput(phaseAInput),
        .phaseBInput(phaseBInput), .indexInput(indexInput), .homeInput(homeInput),
        .position(position), .counterRunning(counterRunning));

    qpc_encoder_model i_enc (.clk(clk), .reset(reset), .cmdStep(cmdStep),
        .cmdIndex(cmdIndex), .cmdHome(cmdHome), .cmdBack(cmdBack), .phaseA(phaseAInput),
        .phaseB(phaseBInput), .indexPin(indexInput), .homePin(homeInput));

    // Comparison with counting
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Register bus cycles
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWriteData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask

    // Read data is valid only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        rdVal = regReadData;
    endtask

    // Encoder action: 0 step, 1 index, 2 home, 3 step back; waits past the synchroniser
    task automatic act(input int which);
        @(posedge clk);
        cmdStep <= (which == 0);
        cmdIndex <= (which == 1);
        cmdHome <= (which == 2);
        cmdBack <= (which == 3);
        @(posedge clk);
        {cmdStep, cmdIndex, cmdHome, cmdBack} <= 4'h0;
        repeat (6) @(posedge clk);
        #1;
    endtask

    // Enabled control word; inv flips the match levels away from the pins
    task automatic ctl(input logic [2:0] mode, input logic [1:0] inv, input logic halt);
        wr(QPC_ADDR_CONTROL, {1'b1, 1'b0, halt, mode, {phaseBInput, phaseAInput} ^ inv, 8'h00});
    endtask

    task automatic t_regs;
        rd(QPC_ADDR_CONTROL);
        check(rdVal, QPC_CONTROL_RESET);
        rd(QPC_ADDR_MODULO);
        check(rdVal, 16'hFFFF);
        wr(QPC_ADDR_CONTROL, 16'hFFFF);
        rd(QPC_ADDR_CONTROL);
        check(rdVal, 16'hBF00);
        rd(4'hF);
        check(rdVal, 16'h0000);
        wr(QPC_ADDR_CONTROL, 16'h0000);
        $display("test registers done");
    endtask

    task automatic t_enable;
        wr(QPC_ADDR_POSITION, 16'h0000);
        act(0);
        act(0);
        check(position, 16'h0000);
        wr(QPC_ADDR_POSITION, 16'h0010);
        rd(QPC_ADDR_POSITION);
        check(rdVal, 16'h0010);
        ctl(3'h0, 2'h0, 1'b0);
        repeat (4) act(0);
        check(position, 16'h0014);
        check({15'h0000, counterRunning}, 16'h0001);
        $display("test enable done");
    endtask

    task automatic t_idle;
        ctl(3'h0, 2'h0, 1'b1);
        @(posedge clk);
        cpuIdle <= 1'b1;
        act(0);
        check({15'h0000, counterRunning}, 16'h0000);
        check(position, 16'h0014);
        ctl(3'h0, 2'h0, 1'b0);
        act(0);
        check(position, 16'h0015);
        check({15'h0000, counterRunning}, 16'h0001);
        @(posedge clk);
        cpuIdle <= 1'b0;
        $display("test idle done");
    endtask

    task automatic t_index;
        wr(QPC_ADDR_INIT_VALUE, 16'h0123);
        for (int m = 0; m < 3; m++) begin
            wr(QPC_ADDR_POSITION, 16'h0005);
            ctl(m[2:0], 2'h0, 1'b0);
            act(1);
            check(position, (m == 0) ? 16'h0005 : (m == 1) ? 16'h0000 : 16'h0123);
        end
        // Each pass moves the phases so both levels of each match bit are used
        for (int k = 1; k < 4; k++) begin
            act(0);
            wr(QPC_ADDR_POSITION, 16'h0005);
            ctl(QPC_MODE_RESET_EACH, k[1:0], 1'b0);
            act(1);
            check(position, 16'h0005);
            ctl(QPC_MODE_RESET_EACH, 2'h0, 1'b0);
            act(1);
            check(position, 16'h0000);
        end
        $display("test index done");
    endtask

    task automatic t_home;
        wr(QPC_ADDR_POSITION, 16'h0005);
        ctl(QPC_MODE_LOAD_FIRST_HOME, 2'h0, 1'b0);
        act(1);
        check(position, 16'h0005);
        act(2);
        act(1);
        check(position, 16'h0123);
        // Sequence finished, home and index pins low again
        rd(QPC_ADDR_STATUS);
        check(rdVal, 16'h000C);
        wr(QPC_ADDR_POSITION, 16'h0005);
        ctl(QPC_MODE_LOAD_SECOND_HOME, 2'h0, 1'b0);
        act(2);
        act(1);
        check(position, 16'h0005);
        act(1);
        check(position, 16'h0123);
        $display("test home done");
    endtask

    task automatic t_wrap;
        wr(QPC_ADDR_POSITION, 16'h0000);
        wr(QPC_ADDR_GE_COMPARE, 16'h0003);
        ctl(QPC_MODE_RESET_GE, 2'h0, 1'b0);
        repeat (3) act(0);
        check(position, 16'h0000);
        act(0);
        check(position, 16'h0001);
        wr(QPC_ADDR_POSITION, 16'h0000);
        wr(QPC_ADDR_MODULO, 16'h0003);
        ctl(QPC_MODE_MODULO, 2'h0, 1'b0);
        repeat (4) act(0);
        check(position, 16'h0000);
        act(0);
        check(position, 16'h0001);
        // Reverse steps wrap from zero back to the modulo value
        act(3);
        check(position, 16'h0000);
        act(3);
        check(position, 16'h0003);
        // Reserved code: index has no effect on the count
        ctl(3'h7, 2'h0, 1'b0);
        act(1);
        check(position, 16'h0003);
        $display("test wrap done");
    endtask

    // Verdict and end of run
    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_enable();
        t_idle();
        t_index();
        t_home();
        t_wrap();
        end_sim();
    end

    // Watchdog, well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        end_sim();
    end
endmodule // tb_quadrature_position_control
